// File: design/bbse_exec.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Executor for zero-clear branch, jump-always and set-bit instructions
// ----------------------------------------------------------------------------
module bbse_exec #(
  parameter int PCW = 21,
  parameter int BANKW = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Fetch side, sampled on the clock that ends the fourth phase.
  input wire logic [bbse_pkg::IW-1:0] instr_i,
  input wire logic [PCW-1:0] instr_addr_i,
  // Core state.
  input wire logic zero_flag_i,
  input wire logic [BANKW-1:0] bank_sel_i,
  // Cycle timing.
  output bbse_pkg::bbse_qphase_e qphase_o,
  output logic nop_cycle_o,
  output logic other_instr_o,
  // Program counter.
  output logic pc_we_o,
  output logic [PCW-1:0] pc_target_o,
  // Data memory.
  output logic mem_rd_o,
  output logic mem_we_o,
  output logic [BANKW+bbse_pkg::REG_MSB:0] mem_addr_o,
  output logic [bbse_pkg::DW-1:0] mem_wdata_o,
  input wire logic [bbse_pkg::DW-1:0] mem_rdata_i
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Classifies an instruction word; anything unknown is left to other units.
  function automatic bbse_pkg::bbse_kind_e decode(input logic [bbse_pkg::IW-1:0] ir);
    if (ir[bbse_pkg::IW-1:bbse_pkg::OPC8_LSB] == bbse_pkg::ZC_OPCODE) begin // [RULE2]
      decode = bbse_pkg::BBSE_KIND_ZERO_CLEAR;
    end else if (ir[bbse_pkg::IW-1:bbse_pkg::OPC5_LSB] == bbse_pkg::JUMP_OPCODE) begin // [RULE5]
      decode = bbse_pkg::BBSE_KIND_JUMP_ALWAYS;
    end else if (ir[bbse_pkg::IW-1:bbse_pkg::OPC4_LSB] == bbse_pkg::SET_BIT_OPCODE) begin // [RULE7]
      decode = bbse_pkg::BBSE_KIND_SET_BIT;
    end else begin
      decode = bbse_pkg::BBSE_KIND_OTHER;
    end
  endfunction : decode

  // The PC has already moved past the branch, hence the extra step of two.
  function automatic logic [PCW-1:0] rel_target(input logic [PCW-1:0] pc,
                                               input logic [bbse_pkg::OFS11_MSB:0] ofs);
    logic [PCW-1:0] wide;
    wide = {{(PCW-bbse_pkg::OFS11_MSB-1){ofs[bbse_pkg::OFS11_MSB]}}, ofs};
    rel_target = pc + PCW'(bbse_pkg::PC_STEP) + (wide << 1); // [RULE3]
  endfunction : rel_target

  // --------------------------------------------------------------------------
  // Phase sequencer and decode
  // --------------------------------------------------------------------------
  bbse_pkg::bbse_qphase_e phase;
  logic [bbse_pkg::IW-1:0] ir_q;
  logic [PCW-1:0] iaddr_q;
  logic nop_q;
  bbse_pkg::bbse_kind_e kind_q;
  bbse_pkg::bbse_kind_e kind_now;
  logic pc_we_q;
  logic [PCW-1:0] pc_target_q;
  logic mem_rd_q;
  logic mem_we_q;
  logic [BANKW+bbse_pkg::REG_MSB:0] mem_addr_q;
  logic [bbse_pkg::DW-1:0] mem_wdata_q;
  logic [bbse_pkg::DW-1:0] bit_mask;
  logic [bbse_pkg::OFS11_MSB:0] ofs8_wide;
  logic end_q1;
  logic end_q2;
  logic end_q3;
  logic end_q4;

  bbse_qphase u_qphase (
    .clk(clk),
    .rst_n(rst_n),
    .phase_o(phase)
  );

  // Each flag marks the clock edge that closes that phase.
  assign end_q1 = (phase == bbse_pkg::BBSE_Q1);
  assign end_q2 = (phase == bbse_pkg::BBSE_Q2);
  assign end_q3 = (phase == bbse_pkg::BBSE_Q3);
  assign end_q4 = (phase == bbse_pkg::BBSE_Q4);

  // A discarded fetch decodes as idle so that nothing acts on it.
  assign kind_now = nop_q ? bbse_pkg::BBSE_KIND_IDLE : decode(ir_q); // [RULE4] [RULE6]

  // The short offset is widened once so one target function serves both branches.
  assign ofs8_wide = {{(bbse_pkg::OFS11_MSB-bbse_pkg::OFS8_MSB){ir_q[bbse_pkg::OFS8_MSB]}},
                      ir_q[bbse_pkg::OFS8_MSB:0]};

  // One-hot mask of the bit that a set-bit instruction forces.
  assign bit_mask = bbse_pkg::DW'(1) << ir_q[bbse_pkg::BIT_MSB:bbse_pkg::BIT_LSB];

  // --------------------------------------------------------------------------
  // Instruction register and discard control
  // --------------------------------------------------------------------------

  // The next word is taken as the cycle ends, whatever this one did.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ir_q <= '0;
      iaddr_q <= '0;
    end else if (end_q4) begin
      ir_q <= instr_i;
      iaddr_q <= instr_addr_i;
    end
  end

  // A PC write in this cycle makes the already fetched word stale, so the next
  // cycle idles; reset also idles the first cycle since no word is held yet.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nop_q <= 1'b1;
    end else if (end_q4) begin
      nop_q <= pc_we_q; // [RULE4] [RULE6]
    end
  end

  // The kind is held from the second phase to the end of the cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kind_q <= bbse_pkg::BBSE_KIND_IDLE;
    end else if (end_q1) begin
      kind_q <= kind_now;
    end else if (end_q4) begin
      kind_q <= bbse_pkg::BBSE_KIND_IDLE;
    end
  end

  // --------------------------------------------------------------------------
  // Program counter write
  // --------------------------------------------------------------------------

  // The decision is made in the third phase and shown for the fourth only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_we_q <= 1'b0;
      pc_target_q <= '0;
    end else if (end_q3) begin
      case (kind_q)
        bbse_pkg::BBSE_KIND_ZERO_CLEAR: begin
          pc_we_q <= !zero_flag_i; // [RULE1] [RULE11]
          pc_target_q <= rel_target(iaddr_q, ofs8_wide); // [RULE3]
        end
        bbse_pkg::BBSE_KIND_JUMP_ALWAYS: begin
          pc_we_q <= 1'b1; // [RULE6]
          pc_target_q <= rel_target(iaddr_q, ir_q[bbse_pkg::OFS11_MSB:0]); // [RULE3]
        end
        default: begin
          pc_we_q <= 1'b0;
        end
      endcase
    end else if (end_q4) begin
      pc_we_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Data memory read-modify-write
  // --------------------------------------------------------------------------

  // Address and read strobe go out for the second phase; the bank is frozen
  // here so a bank change later in the cycle cannot split the access.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_addr_q <= '0;
      mem_rd_q <= 1'b0;
    end else if (end_q1) begin
      if (ir_q[bbse_pkg::BANK_FLAG_BIT]) begin
        mem_addr_q <= {bank_sel_i, ir_q[bbse_pkg::REG_MSB:0]}; // [RULE10]
      end else begin
        mem_addr_q <= {BANKW'(bbse_pkg::ACCESS_BANK), ir_q[bbse_pkg::REG_MSB:0]}; // [RULE9]
      end
      mem_rd_q <= (kind_now == bbse_pkg::BBSE_KIND_SET_BIT); // [RULE8]
    end else if (end_q2) begin
      mem_rd_q <= 1'b0;
    end
  end

  // Read data is taken as the second phase closes and merged at once; the
  // status flags have no path from here, so they stay untouched.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_wdata_q <= '0;
    end else if (end_q2 && kind_q == bbse_pkg::BBSE_KIND_SET_BIT) begin
      mem_wdata_q <= mem_rdata_i | bit_mask; // [RULE8]
    end
  end

  // The write strobe covers the fourth phase of a set-bit cycle only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_we_q <= 1'b0;
    end else if (end_q3) begin
      mem_we_q <= (kind_q == bbse_pkg::BBSE_KIND_SET_BIT); // [RULE8]
    end else if (end_q4) begin
      mem_we_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign qphase_o = phase;
  assign nop_cycle_o = nop_q;
  assign other_instr_o = (kind_q == bbse_pkg::BBSE_KIND_OTHER);
  assign pc_we_o = pc_we_q;
  assign pc_target_o = pc_target_q;
  assign mem_rd_o = mem_rd_q;
  assign mem_we_o = mem_we_q;
  assign mem_addr_o = mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A clear zero flag in the third phase redirects the PC in the fourth.
  a_zc_taken_write: assert property ( // [RULE1]
    (end_q3 && kind_q == bbse_pkg::BBSE_KIND_ZERO_CLEAR && !zero_flag_i) |=> pc_we_o)
    else $error("zero-clear branch not taken with zero flag clear");

  // A set zero flag gives no PC write and no idle cycle.
  a_zc_untaken_quiet: assert property ( // [RULE11]
    (end_q3 && kind_q == bbse_pkg::BBSE_KIND_ZERO_CLEAR && zero_flag_i)
      |=> !pc_we_o ##1 !nop_cycle_o [*4])
    else $error("untaken branch wrote the PC or stalled");

  // The upper byte pattern alone selects the zero-clear branch.
  a_zc_decode_match: assert property ( // [RULE2]
    (end_q1 && !nop_cycle_o && ir_q[bbse_pkg::IW-1:bbse_pkg::OPC8_LSB] == bbse_pkg::ZC_OPCODE)
      |=> kind_q == bbse_pkg::BBSE_KIND_ZERO_CLEAR)
    else $error("zero-clear branch not decoded");

  // Short branch target from an independent sign extension.
  a_short_target: assert property ( // [RULE3]
    (pc_we_o && kind_q == bbse_pkg::BBSE_KIND_ZERO_CLEAR)
      |-> pc_target_o == iaddr_q + PCW'(bbse_pkg::PC_STEP) + (PCW'($signed(ir_q[bbse_pkg::OFS8_MSB:0])) <<< 1))
    else $error("short branch target wrong");

  // Every PC write is followed by exactly one whole idle cycle.
  a_taken_idle_cycle: assert property ( // [RULE4]
    (end_q4 && pc_we_o) |=> nop_cycle_o [*4] ##1 !nop_cycle_o)
    else $error("taken branch not followed by one idle cycle");

  // An idle cycle touches neither memory nor the PC.
  a_idle_no_effect: assert property ( // [RULE4]
    nop_cycle_o |-> !mem_rd_o && !mem_we_o && !pc_we_o && !other_instr_o)
    else $error("discarded fetch had an effect");

  // Jump-always decodes and writes its long target three clocks later.
  a_jump_always_write: assert property ( // [RULE5] [RULE6]
    (end_q1 && !nop_cycle_o && ir_q[bbse_pkg::IW-1:bbse_pkg::OPC5_LSB] == bbse_pkg::JUMP_OPCODE)
      |-> ##3 (pc_we_o && pc_target_o ==
               iaddr_q + PCW'(bbse_pkg::PC_STEP) + (PCW'($signed(ir_q[bbse_pkg::OFS11_MSB:0])) <<< 1)))
    else $error("jump-always did not redirect the PC");

  // Set-bit reads in the second phase and writes in the fourth.
  a_set_bit_sequence: assert property ( // [RULE7]
    (end_q1 && !nop_cycle_o && ir_q[bbse_pkg::IW-1:bbse_pkg::OPC4_LSB] == bbse_pkg::SET_BIT_OPCODE)
      |=> mem_rd_o ##1 !mem_rd_o && !mem_we_o ##1 mem_we_o && !pc_we_o)
    else $error("set-bit read-modify-write out of sequence");

  // Written value is the read value with the chosen bit high.
  a_set_bit_value: assert property ( // [RULE8]
    mem_we_o |-> mem_wdata_o == ($past(mem_rdata_i, 2) | (bbse_pkg::DW'(1) << ir_q[bbse_pkg::BIT_MSB:bbse_pkg::BIT_LSB]))
               && mem_addr_o == $past(mem_addr_o, 2))
    else $error("set-bit write data or address wrong");

  // Selector 0 forces the low bank.
  a_low_bank_select: assert property ( // [RULE9]
    (mem_rd_o && !ir_q[bbse_pkg::BANK_FLAG_BIT])
      |-> mem_addr_o[BANKW+bbse_pkg::REG_MSB:bbse_pkg::REG_MSB+1] == BANKW'(bbse_pkg::ACCESS_BANK))
    else $error("low bank not used with selector 0");

  // Selector 1 takes the bank-select value seen as the first phase closed.
  a_banked_select: assert property ( // [RULE10]
    (mem_rd_o && ir_q[bbse_pkg::BANK_FLAG_BIT])
      |-> mem_addr_o[BANKW+bbse_pkg::REG_MSB:bbse_pkg::REG_MSB+1] == $past(bank_sel_i))
    else $error("bank-select value not used with selector 1");

  // The PC write strobe stands for one clock, and only in the fourth phase.
  a_pc_write_phase: assert property ( // [RULE4]
    pc_we_o |-> qphase_o == bbse_pkg::BBSE_Q4 ##1 !pc_we_o)
    else $error("PC write strobe outside the fourth phase");

  // A word meant for another unit touches neither the PC nor the data memory.
  a_other_no_effect: assert property ( // [RULE7]
    other_instr_o |-> !pc_we_o && !mem_rd_o && !mem_we_o)
    else $error("unhandled instruction had an effect");

  c_zc_taken: cover property (end_q3 && kind_q == bbse_pkg::BBSE_KIND_ZERO_CLEAR && !zero_flag_i);
  c_zc_untaken: cover property (end_q3 && kind_q == bbse_pkg::BBSE_KIND_ZERO_CLEAR && zero_flag_i);
  c_jump_always: cover property (pc_we_o && kind_q == bbse_pkg::BBSE_KIND_JUMP_ALWAYS);
  c_set_bit_banked: cover property (mem_we_o && ir_q[bbse_pkg::BANK_FLAG_BIT]);

endmodule : bbse_exec

// File: design/bbse_pkg.sv
// Summary of operation
// RULE1: Zero-clear branch loads the PC with its target only when the zero flag is 0.
// RULE2: Zero-clear branch decodes from upper byte E1 with a signed 8-bit word offset.
// RULE3: Relative target equals branch address plus 2 plus twice the signed offset.
// RULE4: Conditional branch takes one cycle untaken, two taken; the extra cycle idles.
// RULE5: Jump-always decodes from top five bits 11010 with a signed 11-bit word offset.
// RULE6: Jump-always always writes the PC and always spends a following idle cycle.
// RULE7: Set-bit decodes from top nibble 8, then bit number, bank selector, address.
// RULE8: Set-bit reads the register, forces the chosen bit high, writes back, flags kept.
// RULE9: Bank selector 0 resolves the address in the fixed low bank.
// RULE10: Bank selector 1 takes the bank from the bank-select register.
// RULE11: An untaken conditional branch leaves the PC unwritten in the fourth phase.
package bbse_pkg;

  // --------------------------------------------------------------------------
  // Widths and instruction fields
  // --------------------------------------------------------------------------
  localparam int IW = 16;
  localparam int DW = 8;
  localparam int OPC8_LSB = 8;
  localparam int OPC5_LSB = 11;
  localparam int OPC4_LSB = 12;
  localparam int OFS8_MSB = 7;
  localparam int OFS11_MSB = 10;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int BANK_FLAG_BIT = 8;
  localparam int REG_MSB = 7;

  // --------------------------------------------------------------------------
  // Opcode patterns and fixed values
  // --------------------------------------------------------------------------
  localparam logic [7:0] ZC_OPCODE = 8'hE1;
  localparam logic [4:0] JUMP_OPCODE = 5'h1A;
  localparam logic [3:0] SET_BIT_OPCODE = 4'h8;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam int PC_STEP = 2;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {BBSE_Q1, BBSE_Q2, BBSE_Q3, BBSE_Q4} bbse_qphase_e;
  typedef enum logic [2:0] {
    BBSE_KIND_IDLE,
    BBSE_KIND_ZERO_CLEAR,
    BBSE_KIND_JUMP_ALWAYS,
    BBSE_KIND_SET_BIT,
    BBSE_KIND_OTHER
  } bbse_kind_e;

endpackage : bbse_pkg

// File: design/bbse_qphase.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Quarter-phase sequencer of the instruction cycle
// ----------------------------------------------------------------------------
module bbse_qphase (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Phase of the current instruction cycle.
  output bbse_pkg::bbse_qphase_e phase_o
);

  bbse_pkg::bbse_qphase_e phase_q;

  // Four clocks make one instruction cycle; reset restarts at the first phase.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= bbse_pkg::BBSE_Q1;
    end else begin
      case (phase_q)
        bbse_pkg::BBSE_Q1: phase_q <= bbse_pkg::BBSE_Q2;
        bbse_pkg::BBSE_Q2: phase_q <= bbse_pkg::BBSE_Q3;
        bbse_pkg::BBSE_Q3: phase_q <= bbse_pkg::BBSE_Q4;
        bbse_pkg::BBSE_Q4: phase_q <= bbse_pkg::BBSE_Q1;
        default: phase_q <= bbse_pkg::BBSE_Q1;
      endcase
    end
  end

  assign phase_o = phase_q;

endmodule : bbse_qphase

// File: sim/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Self-checking bench for the branch and set-bit executor
// ----------------------------------------------------------------------------
module tb;
  typedef struct {logic is_pc; logic [20:0] pc; logic [11:0] addr; logic [7:0] data;} bbse_note_s;
  logic clk, rst_n, zero_flag_i, skip, run;
  logic [15:0] instr_i, rnd;
  logic [20:0] instr_addr_i;
  logic [3:0] bank_sel_i;
  logic [7:0] mem_rdata_i, mem_wdata_o;
  bbse_pkg::bbse_qphase_e qphase_o;
  logic nop_cycle_o, other_instr_o, pc_we_o, mem_rd_o, mem_we_o;
  logic [20:0] pc_target_o;
  logic [11:0] mem_addr_o;
  bbse_note_s notes[$];
  bbse_note_s nt;
  logic [2:0] cyc_exp[$];
  logic [2:0] ce;
  logic [20:0] pc_r;
  int error_cnt, n_checks, cyc_cnt;

  bbse_exec DUT (.clk(clk), .rst_n(rst_n), .instr_i(instr_i), .instr_addr_i(instr_addr_i),
    .zero_flag_i(zero_flag_i), .bank_sel_i(bank_sel_i), .qphase_o(qphase_o), .nop_cycle_o(nop_cycle_o),
    .other_instr_o(other_instr_o), .pc_we_o(pc_we_o), .pc_target_o(pc_target_o), .mem_rd_o(mem_rd_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));

  // A 4 ns clock; the timeout counts its edges.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Next state of the stimulus generator; the taps give the longest sequence.
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Every signal comparison goes through here, so unknown values count as mismatches.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Leftover notes mean a strobe or a cycle flag never came.
  task automatic end_sim();
    if (notes.size() != 0 || cyc_exp.size() != 0) error_cnt++;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Drives one word just after the edge that opens Q4 and notes its expected effects.
  // A word fetched behind a taken branch is noted as an idle cycle with no effects.
  task automatic send(input logic [15:0] w, input logic [20:0] here, input logic z, input logic [3:0] bk,
                      input logic [7:0] rd);
    bbse_note_s n;
    logic oth;
    logic setb;
    int k;
    k = 0;
    n = '{default: '0};
    oth = 1'b0;
    setb = 1'b0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (qphase_o !== bbse_pkg::BBSE_Q4 && k < 8);
    instr_i = w;
    instr_addr_i = here;
    zero_flag_i = z;
    bank_sel_i = bk;
    mem_rdata_i = rd;
    if (skip) begin
      cyc_exp.push_back(3'h4);
      skip = 1'b0;
    end else begin
      if (w[15:8] == bbse_pkg::ZC_OPCODE) begin
        if (!z) begin
          n.is_pc = 1'b1;
          n.pc = here + 21'h2 + {{12{w[7]}}, w[7:0], 1'b0};
          notes.push_back(n);
          skip = 1'b1;
        end
      end else if (w[15:11] == bbse_pkg::JUMP_OPCODE) begin
        n.is_pc = 1'b1;
        n.pc = here + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0};
        notes.push_back(n);
        skip = 1'b1;
      end else if (w[15:12] == bbse_pkg::SET_BIT_OPCODE) begin
        n.addr = w[8] ? {bk, w[7:0]} : {bbse_pkg::ACCESS_BANK, w[7:0]};
        n.data = rd | (8'h01 << w[11:9]);
        notes.push_back(n);
        setb = 1'b1;
      end else begin
        oth = 1'b1;
      end
      cyc_exp.push_back({1'b0, setb, oth});
    end
  endtask : send

  // Pops the oldest note; a strobe with nothing noted is a mismatch by itself.
  task automatic take(output bbse_note_s n);
    n = '{default: '0};
    if (notes.size() == 0) chk("unexpected_strobe", 32'h1, 32'h0);
    else n = notes.pop_front();
  endtask : take

  // Watcher: compares every strobe with the oldest note, and the cycle flags once per cycle.
  always @(posedge clk) begin
    #2;
    if (rst_n === 1'b1 && run) begin
      if (qphase_o === bbse_pkg::BBSE_Q2 && cyc_exp.size() > 0) begin
        ce = cyc_exp.pop_front();
        chk("nop_cycle", 32'(nop_cycle_o), 32'(ce[2]));
        chk("other_instr", 32'(other_instr_o), 32'(ce[0]));
        chk("rd_strobe", 32'(mem_rd_o), 32'(ce[1]));
      end
      if (mem_rd_o === 1'b1) begin
        nt = '{default: '0};
        nt.is_pc = 1'b1;
        if (notes.size() > 0) nt = notes[0];
        chk("rd_kind", 32'(nt.is_pc), 32'h0);
        chk("rd_addr", 32'(mem_addr_o), 32'(nt.addr));
      end
      if (pc_we_o === 1'b1) begin
        take(nt);
        chk("pc_kind", 32'(nt.is_pc), 32'h1);
        chk("pc_phase", 32'(qphase_o), 32'(bbse_pkg::BBSE_Q4));
        chk("pc_target", 32'(pc_target_o), 32'(nt.pc));
      end
      if (mem_we_o === 1'b1) begin
        take(nt);
        chk("we_kind", 32'(nt.is_pc), 32'h0);
        chk("we_addr", 32'(mem_addr_o), 32'(nt.addr));
        chk("we_data", 32'(mem_wdata_o), 32'(nt.data));
      end
    end
  end

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  // Main stimulus: reset, directed words, random set-bit words, then a random mix.
  initial begin
    {rst_n, zero_flag_i, skip, run} = 4'h0;
    instr_i = 16'h0000;
    instr_addr_i = 21'h0;
    bank_sel_i = 4'h0;
    mem_rdata_i = 8'h00;
    error_cnt = 0;
    n_checks = 0;
    cyc_cnt = 0;
    rnd = 16'hD415;
    repeat (20) @(posedge clk);
    #1;
    chk("rst_phase", 32'(qphase_o), 32'(bbse_pkg::BBSE_Q1));
    chk("rst_nop", 32'(nop_cycle_o), 32'h1);
    chk("rst_strobes", 32'({pc_we_o, mem_rd_o, mem_we_o}), 32'h0);
    rst_n = 1'b1;
    run = 1'b1;
    send(16'hE105, 21'h000100, 1'b1, 4'h5, 8'h00);
    send(16'h8E34, 21'h000102, 1'b0, 4'h5, 8'h0A);
    send(16'hE180, 21'h000104, 1'b0, 4'h3, 8'h00);
    send(16'h8123, 21'h000106, 1'b0, 4'h3, 8'h00);
    send(16'h8323, 21'h000006, 1'b0, 4'hA, 8'hF0);
    send(16'hE17F, 21'h1FFFFE, 1'b0, 4'h0, 8'h00);
    send(16'h0000, 21'h000000, 1'b0, 4'h0, 8'h00);
    send(16'hD400, 21'h000000, 1'b1, 4'h0, 8'h00);
    send(16'h8E00, 21'h000002, 1'b1, 4'h0, 8'h00);
    send(16'hD3FF, 21'h000800, 1'b0, 4'h0, 8'h00);
    send(16'h0000, 21'h000802, 1'b0, 4'h0, 8'h00);
    send(16'hE300, 21'h000010, 1'b0, 4'h0, 8'h00);
    send(16'hDC00, 21'h000012, 1'b0, 4'h0, 8'h00);
    send(16'h9000, 21'h000014, 1'b0, 4'h0, 8'h00);
    for (int b = 0; b < 8; b++) begin
      rnd = lfsr_next(rnd);
      send({4'h8, b[2:0], rnd[0], rnd[15:8]}, 21'h000020, rnd[1], rnd[5:2], rnd[13:6]);
    end
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr_next(rnd);
      pc_r = {rnd[4:0], lfsr_next(rnd)};
      case (rnd[1:0])
        2'h0: send({8'hE1, pc_r[7:0]}, pc_r, rnd[2], rnd[6:3], rnd[15:8]);
        2'h1: send({5'h1A, pc_r[10:0]}, pc_r, rnd[2], rnd[6:3], rnd[15:8]);
        2'h2: send({4'h8, pc_r[11:0]}, pc_r, rnd[2], rnd[6:3], rnd[15:8]);
        default: send(pc_r[15:0], pc_r, rnd[2], rnd[6:3], rnd[15:8]);
      endcase
    end
    repeat (3) send(16'h0000, 21'h000000, 1'b0, 4'h0, 8'h00);
    repeat (8) @(posedge clk);
    end_sim();
  end
endmodule : tb
